// ### pdc_pkg.sv
// Package for the physical data cache controller: constants and carriers
//
// Function
// - Physical strobe, not logical strobe, drives lookups and termination.
// - Tag compare uses physical address bits only, never function codes.
// - Termination and strobe blocking toward memory qualified by physical strobe.
// - Hit withheld until tag compare has settled, avoiding spurious strobes.
// - Physical address to acknowledge fits about 70 ns, one wait state.
// - General mode: lookup starts after translation completes.
// - Cache within page size: index taken early from processor address.
// - Early index: compare translated address as soon as translation completes.
// - Optional early termination with late retry via fault and halt.
// - Without early termination, translation unit fault or retry terminations reach processor intact.
// - Program-space reads are not treated as instruction-only fetches.
// - Early mode: acknowledge asserted as soon as qualifying strobe asserts.
// - No early termination for CPU space, writes, or retried misses.
// - Termination condition captured at state four for next cycle.
// - From state two in early mode, a cacheable read miss drives fault and halt for retry.
package pdc_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PAGE_BITS = 12;
  localparam int IDX_BITS = 6;
  localparam int OFF_BITS = 2;
  localparam int TAG_W = ADDR_W - IDX_BITS - OFF_BITS;

  // Decision budget with one wait state, and early-retry budget
  localparam int CLK_PERIOD_NS = 50;
  localparam int HIT_BUDGET_NS = 70;
  localparam int RETRY_BUDGET_NS = 55;
  localparam int HIT_BUDGET_CYC = HIT_BUDGET_NS / CLK_PERIOD_NS;
  localparam int RETRY_BUDGET_CYC = RETRY_BUDGET_NS / CLK_PERIOD_NS;
  // Compare settle time in cycles after strobe before hit may show
  localparam logic [1:0] SETTLE_CYC = 2'h1;
  localparam logic [1:0] CPU_SPACE_FC = 2'h3;
  localparam logic [2:0] FC_CPU = 3'h7;

  typedef struct packed {
    logic [ADDR_W-1:0] physAddr;
    logic [DATA_W-1:0] wrData;
    logic [2:0] funcCode;
    logic write;
    logic cacheable;
  } pdc_req_t;

  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] tag;
  } pdc_tag_t;

endpackage

// ### pdc_ctrl.sv
// Physical data cache controller: lookup, termination and retry logic
`timescale 1ns/10ps
`default_nettype none
module pdc_ctrl #(
  parameter int ENTRIES = 64,
  parameter bit EARLY_INDEX = 1'b1,
  parameter bit EARLY_TERM = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic phys_addr_strobe_n,
  input wire logic logical_addr_strobe_n,
  input wire logic busStateTwo,
  input wire logic busStateFour,
  input wire logic [pdc_pkg::PAGE_BITS-1:0] cpuAddrLow,
  input wire pdc_pkg::pdc_req_t req,
  input wire logic [pdc_pkg::DATA_W-1:0] memRdData,
  input wire logic memAck,
  input wire logic mmuFault,
  input wire logic mmuRetry,
  output logic [pdc_pkg::DATA_W-1:0] cacheRdData,
  output logic data_size_ack_n,
  output logic bus_fault_line_n,
  output logic halt_n,
  output logic memStrobe_n
);

  localparam int IW = pdc_pkg::IDX_BITS;
  localparam int TW = pdc_pkg::TAG_W;
  localparam int IL = pdc_pkg::OFF_BITS;

  function automatic logic [IW-1:0] idxOf(
    input logic [pdc_pkg::PAGE_BITS-1:0] a
  );
    idxOf = a[IL+IW-1:IL];
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] pasSync_r;
  logic [1:0] lasSync_r;
  logic [1:0] s2Sync_r;
  logic [1:0] s4Sync_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pasSync_r <= 2'h3;
      lasSync_r <= 2'h3;
      s2Sync_r <= 2'h0;
      s4Sync_r <= 2'h0;
    end else begin
      pasSync_r <= {pasSync_r[0], phys_addr_strobe_n};
      lasSync_r <= {lasSync_r[0], logical_addr_strobe_n};
      s2Sync_r <= {s2Sync_r[0], busStateTwo};
      s4Sync_r <= {s4Sync_r[0], busStateFour};
    end
  end
  // Logical strobe qualifies only the early-mode acknowledge, together with the physical strobe
  wire pasOn = ~pasSync_r[1];
  wire lasOn = ~lasSync_r[1];
  wire st2 = s2Sync_r[1];
  wire st4 = s4Sync_r[1];

  // ----------------------------------------------------------------------
  // Tag and data storage
  // ----------------------------------------------------------------------
  pdc_pkg::pdc_tag_t tagMem_r [ENTRIES];
  logic [pdc_pkg::DATA_W-1:0] dataMem_r [ENTRIES];

  // Early index reads tags from untranslated in-page bits
  wire [IW-1:0] earlyIdx = idxOf(cpuAddrLow);
  wire [IW-1:0] lateIdx = idxOf(req.physAddr[pdc_pkg::PAGE_BITS-1:0]);
  logic [IW-1:0] idx_r;
  wire [IW-1:0] lookIdx = EARLY_INDEX ? idx_r : lateIdx;
  wire pdc_pkg::pdc_tag_t lookTag = tagMem_r[lookIdx];
  // Function codes intentionally absent from the compare
  wire [TW-1:0] reqTag = req.physAddr[pdc_pkg::ADDR_W-1:IW+IL];
  wire tagMatch = lookTag.valid && (lookTag.tag == reqTag);

  // ----------------------------------------------------------------------
  // Cycle control
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, COMPARE, HIT, MISS, DONE} pdc_state_t;
  pdc_state_t state_r;
  pdc_state_t state_nxt;
  logic [1:0] settle_r;
  logic retriedMiss_r;
  logic [pdc_pkg::DATA_W-1:0] rdData_r;
  logic ack_r;
  logic fault_r;
  logic halt_r;
  logic memStb_r;

  wire settled = (settle_r >= pdc_pkg::SETTLE_CYC);
  wire cpuSpace = (req.funcCode == pdc_pkg::FC_CPU);
  // Program-space reads are cached as ordinary data reads
  wire cacheOk = req.cacheable && !cpuSpace;
  wire hitNow = (state_r == COMPARE) && settled && cacheOk && tagMatch;
  wire mmuTerm = mmuFault || mmuRetry;
  // Early termination only where a later hit is likely
  wire earlyOk = EARLY_TERM && cacheOk && !req.write
                 && !retriedMiss_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IDLE: begin
        if (pasOn) begin
          state_nxt = COMPARE;
        end
      end
      COMPARE: begin
        if (!pasOn) begin
          state_nxt = IDLE;
        end else if (mmuTerm) begin
          state_nxt = DONE;
        end else if (settled) begin
          state_nxt = hitNow && !req.write ? HIT : MISS;
        end
      end
      HIT: state_nxt = DONE;
      MISS: begin
        if (memAck || !pasOn) begin
          state_nxt = DONE;
        end
      end
      DONE: begin
        if (!pasOn) begin
          state_nxt = IDLE;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  // Retry drive window: early mode, cacheable read, no hit after state two
  wire lateRetry = EARLY_TERM && st2 && (state_r == MISS) && cacheOk
                   && !req.write && !retriedMiss_r && !mmuTerm;
  // Hit asserts acknowledge within one cycle of settle, within budget
  wire ackNxt = (pasOn && (state_nxt == HIT))
                || (pasOn && earlyOk && lasOn)
                || (state_r == HIT && pasOn);
  // Memory strobe blocked on read hits; released to memory for misses and for all writes
  wire memStbNxt = pasOn && (state_nxt == MISS) && !lateRetry;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= IDLE;
      settle_r <= 2'h0;
      idx_r <= '0;
      ack_r <= 1'b1;
      fault_r <= 1'b1;
      halt_r <= 1'b1;
      memStb_r <= 1'b1;
      rdData_r <= '0;
    end else begin
      state_r <= state_nxt;
      settle_r <= (state_r == COMPARE && !settled) ? settle_r + 2'h1
                : (state_r == COMPARE ? settle_r : 2'h0);
      if (state_r == IDLE) begin
        idx_r <= earlyIdx;
      end
      // Flops hold the active-low pin levels so outputs need no gate
      ack_r <= ~ackNxt;
      fault_r <= ~lateRetry;
      halt_r <= ~lateRetry;
      memStb_r <= ~memStbNxt;
      if (state_nxt == HIT) begin
        rdData_r <= dataMem_r[lookIdx];
      end else if (state_r == MISS && memAck) begin
        rdData_r <= memRdData;
      end
    end
  end

  // Termination condition kept across cycles for the next attempt
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      retriedMiss_r <= 1'b0;
    end else if (st4) begin
      retriedMiss_r <= lateRetry || !fault_r;
    end
  end

  // ----------------------------------------------------------------------
  // Fill and write update
  // ----------------------------------------------------------------------
  wire fillEn = (state_r == MISS) && memAck && cacheOk && !req.write;
  wire wrHit = (state_r == COMPARE) && settled && req.write && cacheOk
               && tagMatch;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tagMem_r[i] <= '0;
        dataMem_r[i] <= '0;
      end
    end else if (fillEn) begin
      tagMem_r[lookIdx] <= '{valid: 1'b1, tag: reqTag};
      dataMem_r[lookIdx] <= memRdData;
    end else if (wrHit) begin
      // Write still goes to memory through the miss path
      dataMem_r[lookIdx] <= req.wrData;
    end
  end

  assign cacheRdData = rdData_r;
  assign data_size_ack_n = ack_r;
  assign bus_fault_line_n = fault_r;
  assign halt_n = halt_r;
  assign memStrobe_n = memStb_r;

endmodule
`default_nettype wire

// ### pdc_ctrl_chk.sv
// Port checker for the physical data cache controller
`timescale 1ns/10ps
`default_nettype none
module pdc_ctrl_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic phys_addr_strobe_n,
  input wire pdc_pkg::pdc_req_t req,
  input wire logic memAck,
  input wire logic mmuFault,
  input wire logic data_size_ack_n,
  input wire logic bus_fault_line_n,
  input wire logic halt_n,
  input wire logic memStrobe_n
);
  // ----
  // Cycle steps
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence cycStart; $fell(phys_addr_strobe_n); endsequence
  sequence passThru; !req.cacheable || req.write || req.funcCode == 3'h7;
  endsequence
  a_ack_on_phys: assert property ($fell(data_size_ack_n) |->
    !$past(phys_addr_strobe_n, 2)) else $error("ack without strobe");
  a_hit_settled: assert property (cycStart |-> data_size_ack_n [*3])
    else $error("ack before compare settled");
  a_hit_blocks_mem: assert property (!data_size_ack_n |->
    !$fell(memStrobe_n)) else $error("memory strobe during hit");
  a_fault_pairs: assert property (!bus_fault_line_n |-> !halt_n)
    else $error("fault without halt");
  a_mem_release: assert property (!memStrobe_n && memAck |->
    ##[1:3] memStrobe_n) else $error("memory strobe stuck");
  a_pass_thru: assert property (cycStart ##0 passThru |->
    ##[1:8] !memStrobe_n) else $error("no memory access");
  a_mmu_no_ack: assert property (mmuFault && data_size_ack_n |=>
    data_size_ack_n) else $error("ack over translation fault");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    data_size_ack_n && memStrobe_n && bus_fault_line_n && halt_n)
    else $error("outputs active after reset");
endmodule
bind pdc_ctrl pdc_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n),
  .phys_addr_strobe_n(phys_addr_strobe_n), .req(req), .memAck(memAck),
  .mmuFault(mmuFault), .data_size_ack_n(data_size_ack_n),
  .bus_fault_line_n(bus_fault_line_n), .halt_n(halt_n),
  .memStrobe_n(memStrobe_n));
`default_nettype wire

// ### pdc_mem.sv
// Behavioural physical memory answering the memory strobe
`timescale 1ns/10ps
`default_nettype none
module pdc_mem (
  input wire logic mclk,
  input wire logic memStrobe_n,
  input wire logic [31:0] addr,
  input wire logic [3:0] dly,
  output logic [31:0] memRdData,
  output logic memAck
);
  logic [3:0] cnt_r = 4'h0;
  // Released data lines toggle so stale data never looks valid
  // Plain always: the start values below come from an initial block
  initial begin
    memAck = 1'b0;
    memRdData = 32'h0;
  end
  always @(posedge mclk) begin
    if (memStrobe_n) begin
      cnt_r <= 4'h0;
      memAck <= 1'b0;
      memRdData <= ~memRdData;
    end else if (cnt_r == dly) begin
      memAck <= 1'b1;
      memRdData <= {addr[15:0], ~addr[15:0]};
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb_physical_data_cache_ctrl.sv
// Testbench for the physical data cache controller
`timescale 1ns/10ps
`default_nettype none
module tb_physical_data_cache_ctrl;
  logic mclk = 1'b0, rst_n = 1'b0, physStb_n = 1'b1, logStb_n = 1'b1;
  logic mmuFault = 1'b0, mmuRetry = 1'b0, memAck, memStrobe_n;
  logic ackN, faultN, haltN;
  logic [11:0] cpuAddrLow = 12'h0;
  logic [31:0] rdData, memData, base;
  logic [3:0] dly = 4'h0;
  pdc_pkg::pdc_req_t req = '0;
  logic vld [64];
  logic [23:0] tagM [64];
  logic [31:0] datM [64];
  int fails = 0, checks = 0, seed = 32'he27aa441;
  always #25 mclk = ~mclk;
  pdc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .phys_addr_strobe_n(physStb_n),
    .logical_addr_strobe_n(logStb_n), .busStateTwo(1'b0),
    .busStateFour(1'b0), .cpuAddrLow(cpuAddrLow), .req(req),
    .memRdData(memData), .memAck(memAck), .mmuFault(mmuFault),
    .mmuRetry(mmuRetry), .cacheRdData(rdData), .data_size_ack_n(ackN),
    .bus_fault_line_n(faultN), .halt_n(haltN), .memStrobe_n(memStrobe_n));
  pdc_mem mem (.mclk(mclk), .memStrobe_n(memStrobe_n), .addr(req.physAddr),
    .dly(dly), .memRdData(memData), .memAck(memAck));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // One bus cycle against the reference model
  // ----
  task automatic cyc(input logic [31:0] a, input logic wr,
    input logic [2:0] fc, input logic cb, input logic [1:0] flt);
    int k;
    logic [31:0] wd;
    logic miss, hit;
    k = int'(a[7:2]);
    wd = $random(seed);
    hit = cb && fc != 3'h7 && vld[k] && tagM[k] == a[31:8];
    miss = 1'b0;
    req = '{a, wd, fc, wr, cb};
    cpuAddrLow = a[11:0];
    logStb_n = 1'b0;
    // Translation delay keeps the two strobes apart
    repeat (2) @(negedge mclk);
    physStb_n = 1'b0;
    {mmuRetry, mmuFault} = flt;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      #1;
      if (!memStrobe_n) miss = 1'b1;
      if (!ackN && !miss || miss && memStrobe_n) break;
    end
    if (flt != 2'h0) check(32'(ackN), 32'h1);
    else check(32'(miss), 32'(wr || !hit));
    if (flt == 2'h0 && hit && !wr) check(rdData, datM[k]);
    if (flt == 2'h0 && cb && fc != 3'h7) begin
      if (wr && hit) datM[k] = wd;
      if (!wr && !hit) begin
        vld[k] = 1'b1;
        tagM[k] = a[31:8];
        datM[k] = {a[15:0], ~a[15:0]};
      end
    end
    @(negedge mclk);
    {physStb_n, logStb_n, mmuFault, mmuRetry} = 4'hc;
    repeat (5) @(negedge mclk);
  endtask
  initial begin
    foreach (vld[j]) vld[j] = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 8; k++) begin
      base = $random(seed);
      base[7:0] = 8'(k * 4);
      dly = 4'(k);
      cyc(base, 1'b0, 3'h5, 1'b1, 2'h0);
      cyc(base, 1'b0, 3'h1, 1'b1, 2'h0);
      cyc(base, 1'b1, 3'h1, 1'b1, 2'h0);
      cyc(base, 1'b0, 3'h7, 1'b1, 2'h0);
      cyc(base, 1'b0, 3'h5, 1'b0, 2'h0);
      cyc(base, 1'b0, 3'h1, 1'b1, 2'h0);
      cyc(base ^ 32'h100, 1'b0, 3'h1, 1'b1, 2'h0);
    end
    cyc(32'h12340ffc, 1'b0, 3'h1, 1'b1, 2'h1);
    cyc(32'h56780ffc, 1'b0, 3'h5, 1'b1, 2'h2);
    finish_test();
  end
  initial begin
    #500000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
